//--- src/dac_override_nvm_access_regs.sv
/*
 Override data, non-volatile control, soft reset, access unlock and
 burst window registers of a temperature-compensated dual DAC.
 Assumes a serial protocol engine on its own clock that delivers start
 address, write and read bytes, and a non-volatile macro and signal
 path logic on sys_clk.
*/
// What this block does
// - a 12-bit override takes effect only when its low byte is written
// - temperature override high nibble at 0x09, low byte at 0x0A
// - first DAC override high nibble at 0x0B, low byte at 0x0C
// - second DAC override high nibble at 0x0D, low byte at 0x0E
// - unused bits 7:4 of override high registers read as zero
// - code 0x4E to the non-volatile register starts a recall
// - burn and recall commands are accepted only at level two
// - status bit 0 reads one while burn or recall runs
// - status bit 2 flags an uncorrectable recall error
// - status bit 1 flags a corrected single bit recall error
// - error flags change only on recall or soft reset, never on burn
// - 0xC3 to 0x10 at level two restores power-up defaults
// - key 0xCD then 0xEF to 0x11 enables level one
// - key 0xCD then 0xF0 to 0x11 enables level two
// - key writes are accepted at the base level
// - access register reads bit 1 for level two, bit 0 level one
// - without limiting the pointer runs to the top then wraps to 0
// - burst control bit 7 enables limiting, writable from level one
// - with limiting a burst covers size plus one bytes then wraps
// - temperature override word indexes the table when selected
// - DAC override words feed both DACs when selected
`timescale 1ns/1ps
`default_nettype none

`include "dac_override_map.svh"

module dac_override_nvm_access_regs
   import dac_override_pkg::*;
(
   // system clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // link clock and serial engine byte port
   input  wire logic        linkClk,
   input  wire logic        linkStart,
   input  wire logic        linkWrite,
   input  wire logic        linkRead,
   input  wire logic [7:0]  linkData,
   output var  logic        linkBusy,
   output var  logic [7:0]  linkRdData,
   output var  logic        linkRdValid,
   // non-volatile macro
   output var  logic        nvmBurnReq,
   output var  logic        nvmRecallReq,
   input  wire logic        nvmDone,
   input  wire logic        nvmSingleErr,
   input  wire logic        nvmMultiErr,
   // signal path
   input  wire logic [1:0]  overrideSelect,
   input  wire logic [11:0] tempSensor,
   input  wire logic [11:0] lutDacA,
   input  wire logic [11:0] lutDacB,
   output var  logic [11:0] lutIndex,
   output var  logic [11:0] dacAInput,
   output var  logic [11:0] dacBInput,
   // soft reset towards the rest of the device
   output var  logic        softResetPulse
);
   import dac_override_pkg::*;

   logic      reqTgl;
   link_cmd_s reqCmd;

   regs_state_s s_reg;
   regs_state_s s_next;
   regs_state_s defaults;

   logic        reqEvent;
   logic [7:0]  wrAddr;
   logic [7:0]  wrData;
   logic        wrEn;
   logic        wrOk;

   // required write level: 0 base, 1 level one, 2 level two
   function automatic logic [1:0] writeLevel(input logic [7:0] addr);
      logic [1:0] lvl;
      lvl = 2'h0;
      case (addr)
         `OFS_TEMP_OVR_HI, `OFS_TEMP_OVR_LO,
         `OFS_DAC_A_OVR_HI, `OFS_DAC_A_OVR_LO,
         `OFS_DAC_B_OVR_HI, `OFS_DAC_B_OVR_LO,
         `OFS_NVM_CMD_STAT, `OFS_SOFT_RESET: lvl = 2'h2;
         `OFS_BURST_CTRL: lvl = 2'h1;
         default: lvl = 2'h0;
      endcase
      return lvl;
   endfunction : writeLevel

   function automatic logic levelGranted(input logic [1:0] need,
                                         input logic       one,
                                         input logic       two);
      logic ok;
      ok = 1'b0;
      case (need)
         2'h0: ok = 1'b1;
         2'h1: ok = one || two;
         2'h2: ok = two;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : levelGranted

   function automatic logic [7:0] readByte(input regs_state_s st);
      logic [7:0] d;
      d = `RST_BYTE;
      case (st.ptr)
         `OFS_TEMP_OVR_HI:  d = {4'h0, st.tempHi};
         `OFS_TEMP_OVR_LO:  d = st.tempLo;
         `OFS_DAC_A_OVR_HI: d = {4'h0, st.dacAHi};
         `OFS_DAC_A_OVR_LO: d = st.dacALo;
         `OFS_DAC_B_OVR_HI: d = {4'h0, st.dacBHi};
         `OFS_DAC_B_OVR_LO: d = st.dacBLo;
         `OFS_NVM_CMD_STAT: begin
            d[`NVM_BUSY_BIT] = st.nvmBusy;
            d[`NVM_COR_BIT]  = st.nvmCorr;
            d[`NVM_UNCORRECTABLE_ERROR_FLAG_BIT] = st.nvmUncorr;
         end
         `OFS_PRIV_UNLOCK: begin
            d[`ACC_L1_BIT] = st.levelOne;
            d[`ACC_L2_BIT] = st.levelTwo;
         end
         `OFS_BURST_CTRL:   d = st.burstCtrl;
         default:           d = `RST_BYTE;
      endcase
      return d;
   endfunction : readByte

   link_crossing u_link (
      .linkClk     (linkClk),
      .rstn        (rstn),
      .linkStart   (linkStart),
      .linkWrite   (linkWrite),
      .linkRead    (linkRead),
      .linkData    (linkData),
      .linkBusy    (linkBusy),
      .linkRdData  (linkRdData),
      .linkRdValid (linkRdValid),
      .reqTgl      (reqTgl),
      .reqCmd      (reqCmd),
      .ackTgl      (s_reg.ackTgl),
      .sysRdData   (s_reg.rdData)
   );

   always_comb begin
      defaults = '0;
      defaults.burstCtrl = `RST_BYTE;
      defaults.keyState = KEY_IDLE;
   end

   // reqCmd is held by the link side until it sees the acknowledge
   assign reqEvent = s_reg.reqSync2 != s_reg.reqSync3;
   assign wrEn     = reqEvent && (reqCmd.kind == LINK_WRITE);
   assign wrAddr   = s_reg.ptr;
   assign wrData   = reqCmd.data;
   assign wrOk     = levelGranted(writeLevel(wrAddr),
                                  s_reg.levelOne, s_reg.levelTwo);

   always_comb begin
      s_next = s_reg;
      s_next.reqSync1 = reqTgl;
      s_next.reqSync2 = s_reg.reqSync1;
      s_next.reqSync3 = s_reg.reqSync2;
      s_next.burnReq = 1'b0;
      s_next.recallReq = 1'b0;
      s_next.softResetPulse = 1'b0;

      // macro completion; a new command in the same cycle still sees busy and is dropped
      if (s_reg.nvmBusy && nvmDone) begin
         s_next.nvmBusy = 1'b0;
         if (s_reg.nvmRecall) begin
            s_next.nvmUncorr = nvmMultiErr;
            s_next.nvmCorr = nvmSingleErr && !nvmMultiErr;
         end
      end

      if (reqEvent) begin
         s_next.ackTgl = ~s_reg.ackTgl;
         case (reqCmd.kind)
            LINK_START: begin
               s_next.ptr = reqCmd.data;
               s_next.blkStart = reqCmd.data;
               s_next.blkCount = 7'h00;
            end
            LINK_READ: begin
               s_next.rdData = readByte(s_reg);
            end
            default: begin
            end
         endcase
         if (reqCmd.kind != LINK_START) begin
            if (s_reg.burstCtrl[`BURST_EN_BIT]) begin
               if (s_reg.blkCount == s_reg.burstCtrl[`BURST_SIZE_MSB:0]) begin
                  s_next.ptr = s_reg.blkStart;
                  s_next.blkCount = 7'h00;
               end else begin
                  s_next.ptr = s_reg.ptr + 8'h01;
                  s_next.blkCount = s_reg.blkCount + 7'h01;
               end
            end else if (s_reg.ptr == `OFS_REG_TOP) begin
               s_next.ptr = 8'h00;
            end else begin
               s_next.ptr = s_reg.ptr + 8'h01;
            end
         end
      end

      // any other write to the unlock register except 0xCD breaks a key sequence
      if (wrEn && wrAddr != `OFS_PRIV_UNLOCK) begin
      end else if (wrEn) begin
         s_next.keyState = KEY_IDLE;
         case (s_reg.keyState)
            KEY_IDLE: begin
               if (wrData == `KEY_FIRST) begin
                  s_next.keyState = KEY_ARMED;
               end
            end
            KEY_ARMED: begin
               if (wrData == `KEY_LEVEL_ONE) begin
                  s_next.levelOne = 1'b1;
               end else if (wrData == `KEY_LEVEL_TWO) begin
                  s_next.levelTwo = 1'b1;
               end else if (wrData == `KEY_FIRST) begin
                  s_next.keyState = KEY_ARMED;
               end
            end
            default: s_next.keyState = KEY_IDLE;
         endcase
      end

      if (wrEn && wrOk) begin
         case (wrAddr)
            `OFS_TEMP_OVR_HI:  s_next.tempHi = wrData[3:0];
            `OFS_TEMP_OVR_LO: begin
               s_next.tempLo = wrData;
               s_next.applied.tempWord = {s_reg.tempHi, wrData};
            end
            `OFS_DAC_A_OVR_HI: s_next.dacAHi = wrData[3:0];
            `OFS_DAC_A_OVR_LO: begin
               s_next.dacALo = wrData;
               s_next.applied.dacAWord = {s_reg.dacAHi, wrData};
            end
            `OFS_DAC_B_OVR_HI: s_next.dacBHi = wrData[3:0];
            `OFS_DAC_B_OVR_LO: begin
               s_next.dacBLo = wrData;
               s_next.applied.dacBWord = {s_reg.dacBHi, wrData};
            end
            `OFS_NVM_CMD_STAT: begin
               // commands while busy are dropped: the macro takes one
               if (!s_reg.nvmBusy) begin
                  if (wrData == `NVM_BURN_CODE) begin
                     s_next.nvmBusy = 1'b1;
                     s_next.nvmRecall = 1'b0;
                     s_next.burnReq = 1'b1;
                  end else if (wrData == `NVM_RECALL_CODE) begin
                     s_next.nvmBusy = 1'b1;
                     s_next.nvmRecall = 1'b1;
                     s_next.recallReq = 1'b1;
                  end
               end
            end
            `OFS_BURST_CTRL:   s_next.burstCtrl = wrData;
            `OFS_SOFT_RESET: begin
               if (wrData == `SOFT_RESET_CODE) begin
                  s_next.softResetPulse = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // soft reset keeps only the handshake so the link is not upset
      if (s_reg.softResetPulse) begin
         s_next = defaults;
         s_next.reqSync1 = reqTgl;
         s_next.reqSync2 = s_reg.reqSync1;
         s_next.reqSync3 = s_reg.reqSync2;
         s_next.ackTgl = s_reg.ackTgl;
         s_next.rdData = s_reg.rdData;
      end

      if (overrideSelect == `SEL_TEMP_OVR) begin
         s_next.lutIndex = s_reg.applied.tempWord;
      end else begin
         s_next.lutIndex = tempSensor;
      end
      if (overrideSelect == `SEL_DAC_OVR) begin
         s_next.dacAOut = s_reg.applied.dacAWord;
         s_next.dacBOut = s_reg.applied.dacBWord;
      end else begin
         s_next.dacAOut = lutDacA;
         s_next.dacBOut = lutDacB;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign nvmBurnReq     = s_reg.burnReq;
   assign nvmRecallReq   = s_reg.recallReq;
   assign lutIndex       = s_reg.lutIndex;
   assign dacAInput      = s_reg.dacAOut;
   assign dacBInput      = s_reg.dacBOut;
   assign softResetPulse = s_reg.softResetPulse;

endmodule : dac_override_nvm_access_regs

`default_nettype wire

//--- pkg/dac_override_map.svh
/*
 Offsets, field positions, command codes and reset values of the
 override, non-volatile control, access and burst window registers.
 Assumes an 8-bit register address space reached one byte at a time.
*/
`ifndef DAC_OVERRIDE_MAP_SVH
`define DAC_OVERRIDE_MAP_SVH

`define OFS_TEMP_OVR_HI    8'h09
`define OFS_TEMP_OVR_LO    8'h0A
`define OFS_DAC_A_OVR_HI   8'h0B
`define OFS_DAC_A_OVR_LO   8'h0C
`define OFS_DAC_B_OVR_HI   8'h0D
`define OFS_DAC_B_OVR_LO   8'h0E
`define OFS_NVM_CMD_STAT   8'h0F
`define OFS_SOFT_RESET     8'h10
`define OFS_PRIV_UNLOCK    8'h11
`define OFS_BURST_CTRL     8'h16
`define OFS_REG_TOP        8'h7F

`define NVM_BURN_CODE      8'hE4
`define NVM_RECALL_CODE    8'h4E
`define SOFT_RESET_CODE    8'hC3
`define KEY_FIRST          8'hCD
`define KEY_LEVEL_ONE      8'hEF
`define KEY_LEVEL_TWO      8'hF0

`define NVM_BUSY_BIT       0
`define NVM_COR_BIT        1
`define NVM_UNCORRECTABLE_ERROR_FLAG_BIT       2
`define ACC_L1_BIT         0
`define ACC_L2_BIT         1
`define BURST_EN_BIT       7
`define BURST_SIZE_MSB     6

`define SEL_TEMP_OVR       2'h1
`define SEL_DAC_OVR        2'h2

`define RST_BYTE           8'h00
`define RST_NIBBLE         4'h0
`define RST_WORD           12'h000

`endif

//--- pkg/dac_override_pkg.sv
/*
 Types shared by the register bank and its link-side crossing.
 Constants live in dac_override_map.svh.
*/
package dac_override_pkg;

   typedef enum logic [1:0] {LINK_START, LINK_WRITE, LINK_READ} link_kind_e;

   typedef struct packed {
      link_kind_e  kind;
      logic [7:0]  data;
   } link_cmd_s;

   typedef enum logic {KEY_IDLE, KEY_ARMED} key_state_e;

   typedef struct packed {
      logic [11:0] tempWord;
      logic [11:0] dacAWord;
      logic [11:0] dacBWord;
   } override_words_s;

   typedef struct packed {
      logic        reqTgl;
      link_cmd_s   cmd;
      logic        ackSync1;
      logic        ackSync2;
      logic        ackSeen;
      logic        busy;
      logic        pendRead;
      logic [7:0]  rdData;
      logic        rdValid;
   } link_state_s;

   typedef struct packed {
      logic            reqSync1;
      logic            reqSync2;
      logic            reqSync3;
      logic            ackTgl;
      logic [7:0]      rdData;
      logic [7:0]      ptr;
      logic [7:0]      blkStart;
      logic [6:0]      blkCount;
      logic [3:0]      tempHi;
      logic [7:0]      tempLo;
      logic [3:0]      dacAHi;
      logic [7:0]      dacALo;
      logic [3:0]      dacBHi;
      logic [7:0]      dacBLo;
      override_words_s applied;
      logic            nvmBusy;
      logic            nvmRecall;
      logic            nvmCorr;
      logic            nvmUncorr;
      logic            burnReq;
      logic            recallReq;
      logic            levelOne;
      logic            levelTwo;
      key_state_e      keyState;
      logic [7:0]      burstCtrl;
      logic            softResetPulse;
      logic [11:0]     lutIndex;
      logic [11:0]     dacAOut;
      logic [11:0]     dacBOut;
   } regs_state_s;

endpackage : dac_override_pkg

//--- src/link_crossing.sv
/*
 Link-side end of the register access path, on the link clock.
 Takes one byte request at a time from the serial engine and hands it
 to the system domain by a toggle handshake; read data come back when
 the acknowledge toggle is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module link_crossing
   import dac_override_pkg::*;
(
   // link clock and reset
   input  wire logic                       linkClk,
   input  wire logic                       rstn,
   // serial engine side
   input  wire logic                       linkStart,
   input  wire logic                       linkWrite,
   input  wire logic                       linkRead,
   input  wire logic [7:0]                 linkData,
   output var  logic                       linkBusy,
   output var  logic [7:0]                 linkRdData,
   output var  logic                       linkRdValid,
   // system side
   output var  logic                       reqTgl,
   output var  dac_override_pkg::link_cmd_s reqCmd,
   input  wire logic                       ackTgl,
   input  wire logic [7:0]                 sysRdData
);
   import dac_override_pkg::*;

   link_state_s s_reg;
   link_state_s s_next;

   always_comb begin
      s_next = s_reg;
      s_next.rdValid = 1'b0;
      s_next.ackSync1 = ackTgl;
      s_next.ackSync2 = s_reg.ackSync1;
      if (s_reg.ackSync2 != s_reg.ackSeen) begin
         s_next.ackSeen = s_reg.ackSync2;
         s_next.busy = 1'b0;
         if (s_reg.pendRead) begin
            // sysRdData is held stable until the next request toggles
            s_next.rdData = sysRdData;
            s_next.rdValid = 1'b1;
         end
      end else if (!s_reg.busy && (linkStart || linkWrite || linkRead)) begin
         s_next.busy = 1'b1;
         s_next.reqTgl = ~s_reg.reqTgl;
         s_next.cmd.data = linkData;
         s_next.pendRead = 1'b0;
         if (linkStart) begin
            s_next.cmd.kind = LINK_START;
         end else if (linkWrite) begin
            s_next.cmd.kind = LINK_WRITE;
         end else begin
            s_next.cmd.kind = LINK_READ;
            s_next.pendRead = 1'b1;
         end
      end
   end

   always_ff @(posedge linkClk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign linkBusy    = s_reg.busy;
   assign linkRdData  = s_reg.rdData;
   assign linkRdValid = s_reg.rdValid;
   assign reqTgl      = s_reg.reqTgl;
   assign reqCmd      = s_reg.cmd;

endmodule : link_crossing

`default_nettype wire

//--- verification/dac_override_assertions.sv
/*
 Port checks for the override register bank on the system clock.
 Assumes binding to dac_override_nvm_access_regs; one reset, one domain.
*/
`timescale 1ns/1ps
`default_nettype none

module dac_override_assertions (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // non-volatile macro
   input wire logic        nvmBurnReq,
   input wire logic        nvmRecallReq,
   input wire logic        nvmDone,
   // signal path
   input wire logic [1:0]  overrideSelect,
   input wire logic [11:0] tempSensor,
   input wire logic [11:0] lutDacA,
   input wire logic [11:0] lutDacB,
   input wire logic [11:0] lutIndex,
   input wire logic [11:0] dacAInput,
   input wire logic [11:0] dacBInput,
   input wire logic        softResetPulse
);
   logic opBusy_reg;

   // tracks an operation handed to the macro until it reports done
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         opBusy_reg <= 1'b0;
      else if (nvmBurnReq || nvmRecallReq)
         opBusy_reg <= 1'b1;
      else if (nvmDone)
         opBusy_reg <= 1'b0;
   end

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_burn_one_pulse: assert property (nvmBurnReq |=> !nvmBurnReq)
      else $error("burn request longer than one cycle");
   a_recall_one_pulse: assert property (nvmRecallReq |=> !nvmRecallReq)
      else $error("recall request longer than one cycle");
   a_nvm_req_exclusive: assert property (!(nvmBurnReq && nvmRecallReq))
      else $error("burn and recall requested together");
   a_nvm_one_running: assert property (
      opBusy_reg |-> !(nvmBurnReq || nvmRecallReq))
      else $error("new macro request while one runs");
   a_reset_one_pulse: assert property (softResetPulse |=> !softResetPulse)
      else $error("soft reset pulse longer than one cycle");
   // sampled rstn keeps the release edge, still in reset, out of it
   a_temp_path_normal: assert property (
      rstn && overrideSelect != 2'h1 |=> lutIndex == $past(tempSensor))
      else $error("table index not from sensor");
   a_dac_path_normal: assert property (
      rstn && overrideSelect != 2'h2 |=>
      dacAInput == $past(lutDacA) && dacBInput == $past(lutDacB))
      else $error("dac inputs not from table path");
   a_soft_reset_clears: assert property (softResetPulse ##0
      (overrideSelect == 2'h2) [*4] |-> dacAInput == 12'h000)
      else $error("override word survives soft reset");
endmodule : dac_override_assertions

bind dac_override_nvm_access_regs dac_override_assertions
   dac_override_assertions_inst (.sys_clk, .rstn, .nvmBurnReq,
   .nvmRecallReq, .nvmDone, .overrideSelect, .tempSensor, .lutDacA,
   .lutDacB, .lutIndex, .dacAInput, .dacBInput, .softResetPulse);

`default_nettype wire

//--- verification/nvm_macro_model.sv
/*
 Behavioural non-volatile macro: answers a burn or recall after a
 short or long delay. Assumes the bench sets the error result lines.
*/
`timescale 1ns/1ps
`default_nettype none

module nvm_macro_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // requests and result control
   input  wire logic burnReq,
   input  wire logic recallReq,
   input  wire logic slow,
   input  wire logic errSingle,
   input  wire logic errMulti,
   // answer
   output logic      nvmDone,
   output logic      nvmSingleErr,
   output logic      nvmMultiErr
);
   logic [7:0] cnt_reg;
   logic       run_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 8'h00;
         run_reg <= 1'b0;
      end else if (burnReq || recallReq) begin
         run_reg <= 1'b1;
         cnt_reg <= slow ? 8'h3C : 8'h03;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 8'h01;
         if (cnt_reg == 8'h00)
            run_reg <= 1'b0;
      end else
         cnt_reg <= cnt_reg + 8'h01;
   end

   assign nvmDone = run_reg && (cnt_reg == 8'h00);
   // result lines are junk outside the done cycle
   assign nvmSingleErr = nvmDone ? errSingle : cnt_reg[0];
   assign nvmMultiErr = nvmDone ? errMulti : ~cnt_reg[0];
endmodule : nvm_macro_model

`default_nettype wire

//--- verification/tb.sv
/*
 Self-checking bench for the override register bank.
 Assumes the byte port, link clock and a behavioural macro model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
   import dac_override_pkg::*;
;
   logic sys_clk, linkClk, rstn, linkStart, linkWrite, linkRead;
   logic linkBusy, linkRdValid, nvmBurnReq, nvmRecallReq, nvmDone;
   logic nvmSingleErr, nvmMultiErr, softResetPulse, slow, errS, errM;
   logic [7:0] linkData, linkRdData, rdv;
   logic [1:0] overrideSelect;
   logic [11:0] tempSensor, lutDacA, lutDacB, lutIndex, dacAInput, dacBInput;
   int fail_count, cmp_count, burnCnt, recallCnt;

   dac_override_nvm_access_regs dac_override_nvm_access_regs_inst (.sys_clk,
      .rstn, .linkClk, .linkStart, .linkWrite, .linkRead, .linkData,
      .linkBusy, .linkRdData, .linkRdValid, .nvmBurnReq, .nvmRecallReq,
      .nvmDone, .nvmSingleErr, .nvmMultiErr, .overrideSelect, .tempSensor,
      .lutDacA, .lutDacB, .lutIndex, .dacAInput, .dacBInput,
      .softResetPulse);
   nvm_macro_model nvm_macro_model_inst (.sys_clk, .rstn,
      .burnReq(nvmBurnReq), .recallReq(nvmRecallReq), .slow,
      .errSingle(errS), .errMulti(errM), .nvmDone, .nvmSingleErr,
      .nvmMultiErr);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #15 linkClk = ~linkClk;
   end
   always @(posedge sys_clk) begin
      if (nvmBurnReq === 1'b1) burnCnt++;
      if (nvmRecallReq === 1'b1) recallCnt++;
   end

   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic sw(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : sw

   // one byte request, held for one link clock, then wait for the answer
   task automatic lop(input link_kind_e k, input logic [7:0] d);
      int n;
      @(posedge linkClk);
      linkStart <= (k == LINK_START);
      linkWrite <= (k == LINK_WRITE);
      linkRead <= (k == LINK_READ);
      linkData <= d;
      @(posedge linkClk);
      linkStart <= 1'b0;
      linkWrite <= 1'b0;
      linkRead <= 1'b0;
      n = 0;
      do begin
         @(posedge linkClk);
         n++;
      end while (linkBusy !== 1'b0 && n < 50);
      rdv = linkRdData;
      chk("link idle", 12'h000, {11'h000, linkBusy});
      chk("read valid", {11'h000, k == LINK_READ}, {11'h000, linkRdValid});
   endtask : lop

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      lop(LINK_START, a);
      lop(LINK_WRITE, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                      input string what);
      lop(LINK_START, a);
      lop(LINK_READ, 8'h00);
      chk(what, {4'h0, e}, {4'h0, rdv});
   endtask : rdc

   function automatic logic [11:0] pick(input int i);
      return (i == 0) ? lutIndex : (i == 1) ? dacAInput : dacBInput;
   endfunction : pick

   task automatic t_access();
      rdc(8'h11, 8'h00, "level at reset");
      wr(8'h0C, 8'h77);
      rdc(8'h0C, 8'h00, "write above level");
      wr(8'h11, 8'hCD);
      wr(8'h11, 8'hEF);
      rdc(8'h11, 8'h01, "level one");
      wr(8'h16, 8'h85);
      rdc(8'h16, 8'h85, "burst control");
      wr(8'h0F, 8'h4E);
      sw(10);
      chk("recall at level one", 12'h000, recallCnt[11:0]);
      wr(8'h11, 8'hCD);
      wr(8'h11, 8'hF0);
      rdc(8'h11, 8'h03, "level two");
      wr(8'h16, 8'h00);
      $display("access test done");
   endtask : t_access

   task automatic t_override();
      logic [11:0] w;
      logic [7:0] a;
      for (int i = 0; i < 3; i++) begin
         w = 12'h73C + 12'(i * 273);
         a = 8'h09 + 8'(2 * i);
         @(posedge sys_clk);
         overrideSelect <= (i == 0) ? 2'h1 : 2'h2;
         wr(a, {4'hF, w[11:8]});
         sw(3);
         chk("high byte alone", 12'h000, pick(i));
         rdc(a, {4'h0, w[11:8]}, "high nibble");
         wr(a + 8'h01, w[7:0]);
         sw(3);
         chk("override word", w, pick(i));
      end
      @(posedge sys_clk);
      overrideSelect <= 2'h0;
      sw(3);
      chk("sensor index", tempSensor, lutIndex);
      chk("table dac", lutDacA, dacAInput);
      chk("table dac b", lutDacB, dacBInput);
      $display("override test done");
   endtask : t_override

   task automatic t_nvm();
      @(posedge sys_clk);
      slow <= 1'b1;
      errS <= 1'b1;
      wr(8'h0F, 8'h11);
      sw(10);
      chk("unknown command", 12'h000, 12'(burnCnt + recallCnt));
      wr(8'h0F, 8'h4E);
      rdc(8'h0F, 8'h01, "busy in recall");
      sw(80);
      rdc(8'h0F, 8'h02, "corrected error");
      @(posedge sys_clk);
      slow <= 1'b0;
      errM <= 1'b1;
      wr(8'h0F, 8'h4E);
      sw(80);
      rdc(8'h0F, 8'h04, "uncorrectable error");
      @(posedge sys_clk);
      errM <= 1'b0;
      errS <= 1'b0;
      wr(8'h0F, 8'hE4);
      sw(80);
      rdc(8'h0F, 8'h04, "flags after burn");
      chk("burn count", 12'h001, burnCnt[11:0]);
      chk("recall count", 12'h002, recallCnt[11:0]);
      $display("nvm test done");
   endtask : t_nvm

   task automatic t_burst();
      lop(LINK_START, 8'h7F);
      repeat (11) lop(LINK_READ, 8'h00);
      chk("pointer wrap", 12'h007, {4'h0, rdv});
      wr(8'h16, 8'h81);
      lop(LINK_START, 8'h0B);
      repeat (3) lop(LINK_READ, 8'h00);
      chk("window wrap", 12'h008, {4'h0, rdv});
      wr(8'h16, 8'h00);
      $display("burst test done");
   endtask : t_burst

   task automatic t_softreset();
      @(posedge sys_clk);
      overrideSelect <= 2'h2;
      wr(8'h10, 8'hC3);
      sw(5);
      chk("dac after soft reset", 12'h000, dacAInput);
      rdc(8'h11, 8'h00, "level after soft reset");
      wr(8'h0C, 8'h12);
      rdc(8'h0C, 8'h00, "write at base level");
      $display("soft reset test done");
   endtask : t_softreset

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   initial begin
      #200_000;
      fail_count++;
      close_out();
   end

   initial begin
      rstn = 1'b0;
      {linkStart, linkWrite, linkRead, slow, errS, errM} = 6'h00;
      linkData = 8'h00;
      overrideSelect = 2'h0;
      tempSensor = 12'h5A5;
      lutDacA = 12'h3C6;
      lutDacB = 12'hC39;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge linkClk);
      t_access();
      t_override();
      t_nvm();
      t_burst();
      t_softreset();
      close_out();
   end
endmodule : tb

`default_nettype wire
